// [ism_master.sv]
/*
  Single-master two-wire bus interface: control, status, data and clock
  control words as plain ports, start/address/data/ack/stop sequencing.
  Assumes processor strobes are one-cycle pulses synchronous to clk_in
  and that bus pins are resolved externally from the open-drain enables.
*/
// Summary of operation
// - Idle after reset, master after start, idle after stop.
// - Bytes shift eight bits, MSB first, address first.
// - Ninth clock pulse carries the acknowledge bit.
// - Software picks standard or fast clock range.
// - Transmit holds clock low until data written.
// - Receive holds clock low until data read.
// - Start sets master flag, then event and start flags.
// - After start, wait status read then address write.
// - After address, wait status read then control write.
// - Receive: ack pulse, then event and byte flags.
// - Receive byte flag cleared by status then data read.
// - Transmit waits status read then next data write.
// - Transmit: slave ack sets event and byte flags.
// - Missing ack flags failure, clock not held.
// - Halt freezes registers and ignores the bus.
// - Wait state does not affect the interface.
// - Four events share one masked interrupt request.
// - Enabled pins are open drain, disabled return to port.
// - Programmable divider depends on speed mode.
// - Divider gives factor two or three times value plus two.
// - Enabling takes two control writes, first only enable and stop.
// - Disabled clears flags, state and control bits but stop, releases outputs.
`timescale 1ns/1ps
module ism_master
  import ism_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // Processor side
  input  ism_pkg::ism_cpu_t cpu_in,
  input  wire logic       halt_in,
  input  wire logic       wait_in,
  input  wire logic       cpu_imask_in,
  output logic [7:0]      control_reg_out,
  output logic [7:0]      status_one_reg_out,
  output logic [7:0]      status_two_reg_out,
  output logic [7:0]      data_register_out,
  output logic [7:0]      clock_ctrl_out,
  output logic            irq_out,
  output logic            port_select_out,
  // Bus pins
  input  wire logic       bus_clock_pin_in,
  input  wire logic       bus_data_pin_in,
  output ism_pkg::ism_pins_t pins_out
);
  import ism_pkg::*;

  //--------------------------------------------------------------
  // Registers
  //--------------------------------------------------------------
  logic       peripheral_on_q, start_q, ack_en_q, stop_q, irq_enable_q;
  logic       event_pending_q, tra_q, byte_done_flag_q, master_active_flag_q, start_sent_flag_q;
  logic       ack_failure_flag_q, addr_done_q, is_addr_q, rx_mode_q, sr1_seen_q;
  logic       fast_mode_select_q;
  logic [6:0] speed_divider_q;
  logic [7:0] data_register_q;
  logic       scl_low_q, sda_low_q;
  ism_state_t state_q;

  logic       run, tick, load, shift, msb;
  logic [7:0] sh_data;
  logic [3:0] bit_cnt;
  logic       set_sb, set_btf, set_af, set_adr;
  logic       clr_seq_wr, clr_seq_rd, clr_cr;

  // Halt freezes all registers, clears the tick count and releases the data pin; wait has no effect at all
  assign run = !halt_in && peripheral_on_q;

  ism_tick_gen #(.DW(DIV_W)) u_tick (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .run_in   (run && state_q != ISM_IDLE && state_q != ISM_HOLD),
    .fast_in  (fast_mode_select_q),
    .div_in   (speed_divider_q),
    .tick_out (tick)
  );

  ism_shifter u_shift (
    .clk_in       (clk_in),
    .rst_n_in     (rst_n_in),
    .load_in      (load),
    .load_data_in (cpu_in.dr_wr ? cpu_in.wdata : BYTE_RESET),
    .shift_in     (shift),
    .sample_in    (bus_data_pin_in),
    .msb_out      (msb),
    .data_out     (sh_data),
    .count_out    (bit_cnt)
  );

  // Clear sequences: status one read arms, next access completes
  assign clr_seq_wr = sr1_seen_q && cpu_in.dr_wr && !halt_in;
  assign clr_seq_rd = sr1_seen_q && cpu_in.dr_rd && !halt_in;
  assign clr_cr     = sr1_seen_q && cpu_in.cr_wr && !halt_in;

  // Byte launch when a hold is released; transmit waits for its data write
  // Written byte goes straight to the shifter, on the same edge as the register copy
  assign load  = run && state_q == ISM_HOLD &&
                 ((start_sent_flag_q && clr_seq_wr) ||
                  (addr_done_q && rx_mode_q && clr_cr && cpu_in.wdata[CR_PE]) ||
                  (!rx_mode_q && !is_addr_q && !start_sent_flag_q && !addr_done_q &&
                   clr_seq_wr) ||
                  (byte_done_flag_q && rx_mode_q && clr_seq_rd && !stop_q));
  assign shift = run && tick && state_q == ISM_BIT_HI && bit_cnt < BITS_PER_BYTE;

  assign set_sb  = run && tick && state_q == ISM_START && !scl_low_q;
  assign set_af  = run && tick && state_q == ISM_BIT_HI && bit_cnt == ACK_SLOT &&
                   !rx_mode_q && bus_data_pin_in;
  assign set_adr = run && tick && state_q == ISM_BIT_HI && bit_cnt == ACK_SLOT &&
                   is_addr_q && !bus_data_pin_in;
  assign set_btf = run && tick && state_q == ISM_BIT_HI && bit_cnt == ACK_SLOT &&
                   !is_addr_q && (rx_mode_q || !bus_data_pin_in);

  //--------------------------------------------------------------
  // Control word
  //--------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      peripheral_on_q <= 1'b0;
      start_q         <= 1'b0;
      ack_en_q        <= 1'b0;
      stop_q          <= 1'b0;
      irq_enable_q    <= 1'b0;
    end else if (!halt_in) begin
      if (cpu_in.cr_wr) begin
        peripheral_on_q <= cpu_in.wdata[CR_PE];
        stop_q          <= cpu_in.wdata[CR_STOP];
      end else if (peripheral_on_q && state_q == ISM_STOP_C && tick) begin
        stop_q <= 1'b0;
      end
      // First enabling write only turns the block on and loads stop
      if (cpu_in.cr_wr && peripheral_on_q && cpu_in.wdata[CR_PE]) begin
        start_q      <= cpu_in.wdata[CR_START];
        ack_en_q     <= cpu_in.wdata[CR_ACK];
        irq_enable_q <= cpu_in.wdata[CR_ITE];
      end else if (!peripheral_on_q || cpu_in.cr_wr) begin
        // Disabling write clears at once, not a cycle later
        start_q      <= 1'b0;
        ack_en_q     <= 1'b0;
        irq_enable_q <= 1'b0;
      end else if (set_sb) begin
        start_q <= 1'b0;
      end
    end
  end

  // Clock control survives disable
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      fast_mode_select_q <= 1'b0;
      speed_divider_q    <= 7'h00;
    end else if (!halt_in && cpu_in.ccr_wr) begin
      fast_mode_select_q <= cpu_in.wdata[DIV_W];
      speed_divider_q    <= cpu_in.wdata[DIV_W-1:0];
    end
  end

  //--------------------------------------------------------------
  // Status flags: a set in the same cycle beats a clear
  //--------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || (!peripheral_on_q && !halt_in)) begin
      start_sent_flag_q  <= 1'b0;
      byte_done_flag_q   <= 1'b0;
      ack_failure_flag_q <= 1'b0;
      addr_done_q        <= 1'b0;
      tra_q              <= 1'b0;
      sr1_seen_q         <= 1'b0;
    end else if (!halt_in) begin
      if (set_sb) begin
        start_sent_flag_q <= 1'b1;
      end else if (clr_seq_wr) begin
        start_sent_flag_q <= 1'b0;
      end
      if (set_btf) begin
        byte_done_flag_q <= 1'b1;
        tra_q            <= !rx_mode_q;
      end else if (clr_seq_wr || clr_seq_rd) begin
        byte_done_flag_q <= 1'b0;
        tra_q            <= 1'b0;
      end
      if (set_af) begin
        ack_failure_flag_q <= 1'b1;
      end else if (cpu_in.sr2_rd) begin
        ack_failure_flag_q <= 1'b0;
      end
      if (set_adr) begin
        addr_done_q <= 1'b1;
      end else if (clr_cr) begin
        addr_done_q <= 1'b0;
      end
      if (cpu_in.sr1_rd) begin
        sr1_seen_q <= 1'b1;
      end else if (cpu_in.dr_wr || cpu_in.dr_rd || cpu_in.cr_wr) begin
        sr1_seen_q <= 1'b0;
      end
    end
  end

  always_comb begin
    event_pending_q = start_sent_flag_q || byte_done_flag_q || ack_failure_flag_q || addr_done_q;
  end

  //--------------------------------------------------------------
  // Data register and receive direction
  //--------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      data_register_q <= BYTE_RESET;
      rx_mode_q       <= 1'b0;
      is_addr_q       <= 1'b0;
    end else if (!halt_in) begin
      if (cpu_in.dr_wr) begin
        data_register_q <= cpu_in.wdata;
      end else if (set_btf && rx_mode_q) begin
        data_register_q <= sh_data;
      end
      if (start_sent_flag_q && clr_seq_wr) begin
        is_addr_q <= 1'b1;
        rx_mode_q <= 1'b0;
      end else if (set_adr) begin
        is_addr_q <= 1'b0;
        rx_mode_q <= data_register_q[0];
      end
    end
  end

  //--------------------------------------------------------------
  // Bus sequencer
  //--------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || (!peripheral_on_q && !halt_in)) begin
      state_q              <= ISM_IDLE;
      master_active_flag_q <= 1'b0;
      scl_low_q            <= 1'b0;
      sda_low_q            <= 1'b0;
    end else if (run) begin
      unique case (state_q)
        ISM_IDLE: begin
          if (start_q) begin
            master_active_flag_q <= 1'b1;
            state_q              <= ISM_START;
          end else if (stop_q && master_active_flag_q) begin
            state_q <= ISM_STOP_A;
          end
        end
        ISM_START: begin
          if (tick) begin
            if (scl_low_q) begin
              scl_low_q <= 1'b0;
              sda_low_q <= 1'b0;
            end else begin
              sda_low_q <= 1'b1;
              state_q   <= ISM_HOLD;
            end
          end
        end
        ISM_HOLD: begin
          // Clock stays low while software owes an access
          scl_low_q <= 1'b1;
          if (load) begin
            state_q <= ISM_BIT_LO;
          end else if (start_q && !start_sent_flag_q) begin
            state_q <= ISM_START;
          end else if (stop_q && !event_pending_q) begin
            state_q <= ISM_STOP_A;
          end
        end
        ISM_BIT_LO: begin
          if (tick) begin
            scl_low_q <= 1'b0;
            if (bit_cnt == ACK_SLOT) begin
              sda_low_q <= rx_mode_q && ack_en_q;
            end else begin
              sda_low_q <= !rx_mode_q && !msb;
            end
            state_q <= ISM_BIT_HI;
          end
        end
        ISM_BIT_HI: begin
          if (tick) begin
            scl_low_q <= 1'b1;
            if (bit_cnt == ACK_SLOT) begin
              sda_low_q <= 1'b0;
              if (set_af) begin
                state_q <= ISM_HOLD;
              end else if (stop_q) begin
                state_q <= ISM_STOP_A;
              end else begin
                state_q <= ISM_HOLD;
              end
            end else begin
              state_q <= ISM_BIT_LO;
            end
          end
        end
        ISM_STOP_A: begin
          if (tick) begin
            scl_low_q <= 1'b1;
            sda_low_q <= 1'b1;
            state_q   <= ISM_STOP_B;
          end
        end
        ISM_STOP_B: begin
          if (tick) begin
            scl_low_q <= 1'b0;
            state_q   <= ISM_STOP_C;
          end
        end
        ISM_STOP_C: begin
          if (tick) begin
            sda_low_q            <= 1'b0;
            master_active_flag_q <= 1'b0;
            state_q              <= ISM_IDLE;
          end
        end
        default: begin
          state_q <= ISM_IDLE;
        end
      endcase
    end
  end

  //--------------------------------------------------------------
  // Outputs
  //--------------------------------------------------------------
  // Failure leaves the clock released; hold only for other owed events
  assign pins_out.scl_o  = 1'b0;
  assign pins_out.sda_o  = 1'b0;
  assign pins_out.scl_oe = peripheral_on_q && scl_low_q &&
                           !(state_q == ISM_HOLD && ack_failure_flag_q && !byte_done_flag_q);
  assign pins_out.sda_oe = peripheral_on_q && sda_low_q && !halt_in;
  assign port_select_out = peripheral_on_q;

  assign irq_out = irq_enable_q && !cpu_imask_in &&
                   (start_sent_flag_q || byte_done_flag_q || ack_failure_flag_q || addr_done_q);

  assign control_reg_out    = {2'b00, peripheral_on_q, 1'b0, start_q, ack_en_q, stop_q, irq_enable_q};
  assign status_one_reg_out = {event_pending_q, 1'b0, tra_q, 1'b0, byte_done_flag_q, 1'b0,
                               master_active_flag_q, start_sent_flag_q};
  assign status_two_reg_out = {3'b000, ack_failure_flag_q, 4'h0};
  assign data_register_out  = data_register_q;
  assign clock_ctrl_out     = {fast_mode_select_q, speed_divider_q};

  //--------------------------------------------------------------
  // Checks
  //--------------------------------------------------------------
  idle_reset_a: assert property (@(posedge clk_in) !rst_n_in |=> state_q == ISM_IDLE && !master_active_flag_q)
    else $error("not idle after reset");
  irq_gate_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    irq_out |-> irq_enable_q && !cpu_imask_in && event_pending_q) else $error("irq without cause");
  sb_sets_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    set_sb |=> start_sent_flag_q && event_pending_q && master_active_flag_q) else $error("start flags missing");
  hold_low_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state_q == ISM_HOLD && byte_done_flag_q && $past(state_q) == ISM_HOLD |-> pins_out.scl_oe)
    else $error("clock released while byte pending");
  af_free_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state_q == ISM_HOLD && ack_failure_flag_q && !byte_done_flag_q |-> !pins_out.scl_oe)
    else $error("clock held on ack failure");
  off_clear_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !peripheral_on_q && !halt_in |=> !start_q && !event_pending_q && !pins_out.scl_oe) else $error("disable left state");
  halt_frozen_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    halt_in && $past(halt_in) |-> $stable(data_register_q) && $stable(state_q)) else $error("halt not frozen");
  first_pe_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cpu_in.cr_wr && !halt_in && !peripheral_on_q |=> !start_q && !irq_enable_q) else $error("first write took bits");
  rx_store_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    set_btf && rx_mode_q && !cpu_in.dr_wr |=> data_register_q == $past(sh_data)) else $error("rx byte lost");

  cov_start_c: cover property (@(posedge clk_in) disable iff (!rst_n_in) set_sb);
  cov_btf_c:   cover property (@(posedge clk_in) disable iff (!rst_n_in) set_btf && rx_mode_q);
  cov_af_c:    cover property (@(posedge clk_in) disable iff (!rst_n_in) set_af);
  cov_stop_c:  cover property (@(posedge clk_in) disable iff (!rst_n_in) state_q == ISM_STOP_C && tick);

endmodule

// [ism_pkg.sv]
/*
  Package for the single-master two-wire interface: bit positions, reset
  values, divider factors, states and the grouped port structs.
  Assumes nothing of its surroundings.
*/
package ism_pkg;

  localparam int unsigned CLK_HZ        = 25000000;
  localparam int unsigned DIV_W         = 7;
  localparam logic [7:0]  BYTE_RESET    = 8'h00;
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
  localparam logic [3:0]  ACK_SLOT      = 4'h8;
  localparam logic [3:0]  BIT_ZERO      = 4'h0;
  localparam logic [1:0]  STD_FACTOR    = 2'h2;
  localparam logic [1:0]  FAST_FACTOR   = 2'h3;
  localparam logic [7:0]  DIV_OFFSET    = 8'h02;
  localparam logic [9:0]  CNT_ONE       = 10'h001;

  // Control word bit positions
  localparam int CR_PE    = 5;
  localparam int CR_START = 3;
  localparam int CR_ACK   = 2;
  localparam int CR_STOP  = 1;
  localparam int CR_ITE   = 0;
  // Status one bit positions
  localparam int S1_EVF   = 7;
  localparam int S1_TRA   = 5;
  localparam int S1_BTF   = 3;
  localparam int S1_MSL   = 1;
  localparam int S1_SB    = 0;
  // Status two bit positions
  localparam int S2_AF    = 4;

  typedef enum logic [3:0] {
    ISM_IDLE   = 4'h0,
    ISM_START  = 4'h1,
    ISM_HOLD   = 4'h2,
    ISM_BIT_LO = 4'h3,
    ISM_BIT_HI = 4'h4,
    ISM_STOP_A = 4'h5,
    ISM_STOP_B = 4'h6,
    ISM_STOP_C = 4'h7
  } ism_state_t;

  // Processor side access strobes, one-cycle pulses
  typedef struct packed {
    logic       cr_wr;
    logic       dr_wr;
    logic       dr_rd;
    logic       sr1_rd;
    logic       sr2_rd;
    logic       ccr_wr;
    logic [7:0] wdata;
  } ism_cpu_t;

  // Open-drain bus pins: output level and enable
  typedef struct packed {
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
  } ism_pins_t;

endpackage

// [ism_tick_gen.sv]
/*
  Half-period tick generator for the bus clock.
  Assumes the divider value and mode are stable during a byte.
*/
`timescale 1ns/1ps
module ism_tick_gen
  import ism_pkg::*;
#(
  parameter int DW = DIV_W
) (
  // Clock and reset
  input  wire logic          clk_in,
  input  wire logic          rst_n_in,
  // Control
  input  wire logic          run_in,
  input  wire logic          fast_in,
  input  wire logic [DW-1:0] div_in,
  // Tick out
  output logic               tick_out
);
  import ism_pkg::*;

  logic [9:0] cnt_q;
  logic [9:0] span;

  // Period = factor*(div+2) cycles, rounded down to an even count; a half period of it between edges
  always_comb begin
    span = (fast_in ? 10'(FAST_FACTOR) : 10'(STD_FACTOR)) * (10'(div_in) + 10'(DIV_OFFSET));
    span = span >> 1;
    if (span == 10'h000) begin
      span = CNT_ONE;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in || !run_in) begin
      cnt_q <= 10'h000;
    end else if (cnt_q + CNT_ONE >= span) begin
      cnt_q <= 10'h000;
    end else begin
      cnt_q <= cnt_q + CNT_ONE;
    end
  end

  assign tick_out = run_in && (cnt_q + CNT_ONE >= span);

  cov_tick_c: cover property (@(posedge clk_in) disable iff (!rst_n_in) tick_out);

endmodule

// [ism_shifter.sv]
/*
  Byte shifter: MSB-first shift register with a bit counter.
  Assumes the controller loads, shifts and samples on its own strobes.
*/
`timescale 1ns/1ps
module ism_shifter
  import ism_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // Control
  input  wire logic       load_in,
  input  wire logic [7:0] load_data_in,
  input  wire logic       shift_in,
  input  wire logic       sample_in,
  // State
  output logic            msb_out,
  output logic [7:0]      data_out,
  output logic [3:0]      count_out
);
  import ism_pkg::*;

  logic [7:0] sh_q;
  logic [3:0] cnt_q;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sh_q  <= BYTE_RESET;
      cnt_q <= BIT_ZERO;
    end else if (load_in) begin
      sh_q  <= load_data_in;
      cnt_q <= BIT_ZERO;
    end else if (shift_in) begin
      sh_q  <= {sh_q[6:0], sample_in};
      cnt_q <= cnt_q + 4'h1;
    end
  end

  assign msb_out   = sh_q[7];
  assign data_out  = sh_q;
  assign count_out = cnt_q;

  bit_count_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    shift_in && !load_in |=> count_out == $past(count_out) + 4'h1) else $error("bit count did not step");

endmodule

// [ism_slave_model.sv]
/*
  Behavioural slave on the two-wire bus: acks its address, takes writes,
  returns a counting byte stream on reads.
  Assumes resolved bus levels with pull-ups, sampled on the bench clock.
*/
`timescale 1ns/1ps
module ism_slave_model #(
  parameter logic [6:0] ADDR = 7'h2a
) (
  input  wire logic clk_in,
  input  wire logic scl_in,
  input  wire logic sda_in,
  input  wire logic nack_in,
  output logic      sda_oe_out
);
  logic       scl_q = 1'b1;
  logic       sda_q = 1'b1;
  logic       act_q = 1'b0;
  logic       rd_q = 1'b0;
  logic       first_q = 1'b0;
  logic [3:0] cnt_q = 4'h0;
  logic [7:0] sh_q = 8'h00;
  logic [7:0] tx_q = 8'h00;
  initial sda_oe_out = 1'b0;
  always @(posedge clk_in) begin
    scl_q <= scl_in;
    sda_q <= sda_in;
    if (scl_in && scl_q && sda_q && !sda_in) begin
      act_q <= 1'b1;
      first_q <= 1'b1;
      cnt_q <= 4'h0;
      tx_q <= 8'hc3;
      sda_oe_out <= 1'b0;
    end else if (scl_in && scl_q && !sda_q && sda_in) begin
      act_q <= 1'b0;
      sda_oe_out <= 1'b0;
    end else if (act_q && scl_in && !scl_q) begin
      if (cnt_q == 4'h8) begin
        cnt_q <= 4'h0;
        first_q <= 1'b0;
        // Master non-ack ends the read stream
        if (rd_q && !first_q) begin
          tx_q <= tx_q + 8'h01;
          act_q <= !sda_in;
        end
      end else begin
        sh_q <= {sh_q[6:0], sda_in};
        cnt_q <= cnt_q + 4'h1;
      end
    end else if (act_q && !scl_in && scl_q) begin
      if (cnt_q == 4'h8 && first_q) begin
        rd_q <= sh_q[0];
        sda_oe_out <= (sh_q[7:1] == ADDR) && !nack_in;
      end else if (cnt_q == 4'h8) begin
        sda_oe_out <= !rd_q && !nack_in;
      end else begin
        sda_oe_out <= rd_q && !first_q && !tx_q[3'h7 - cnt_q[2:0]];
      end
    end
  end
endmodule

// [ism_master_bench.sv]
/*
  Bench for the single-master two-wire interface: strobe tasks, a slave
  model on the resolved bus, and checks of flags, data and the wire.
  Assumes the package and the slave model are compiled first.
*/
`timescale 1ns/1ps
module ism_master_bench;
  import ism_pkg::*;
  localparam logic [5:0] CRW = 6'h20, DRW = 6'h10, DRR = 6'h08, S1R = 6'h04, S2R = 6'h02, CCW = 6'h01;
  logic       clk_in = 1'b0;
  logic       rst_n_in = 1'b0;
  logic       halt_in = 1'b0;
  logic       wait_in = 1'b0;
  logic       imask = 1'b0;
  logic       nack = 1'b0;
  logic       scl_d = 1'b1;
  ism_cpu_t   cpu = '0;
  ism_pins_t  pins;
  logic [7:0] ctl, st1, st2, dat, ccr;
  logic       irq, psel, s_oe;
  logic [8:0] bits = 9'h000;
  int         per = 0;
  int         cyc = 0;
  int         cycles = 0;
  int         err_total = 0;
  int         checked = 0;
  // Open-drain wires with pull-ups
  wire        scl = !pins.scl_oe;
  wire        sda = !(pins.sda_oe || s_oe);

  ism_master dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .cpu_in(cpu), .halt_in(halt_in), .wait_in(wait_in),
    .cpu_imask_in(imask), .control_reg_out(ctl), .status_one_reg_out(st1), .status_two_reg_out(st2),
    .data_register_out(dat), .clock_ctrl_out(ccr), .irq_out(irq), .port_select_out(psel),
    .bus_clock_pin_in(scl), .bus_data_pin_in(sda), .pins_out(pins));
  ism_slave_model slave_u (.clk_in(clk_in), .scl_in(scl), .sda_in(sda), .nack_in(nack), .sda_oe_out(s_oe));

  always #20 clk_in = !clk_in;

  // ----------------------------------------
  // Wire monitor: last nine bits, clock period
  // ----------------------------------------
  always @(posedge clk_in) begin
    scl_d <= scl;
    cyc <= (scl && !scl_d) ? 1 : cyc + 1;
    if (scl && !scl_d) begin
      bits <= {bits[7:0], sda};
      per <= cyc;
    end
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic acc(input logic [5:0] s, input logic [7:0] d);
    @(posedge clk_in);
    cpu <= {s, d};
    @(posedge clk_in);
    cpu <= '0;
    #1;
  endtask

  // Bounded wait on one status bit
  task automatic wfs(input int b, input logic v);
    int n;
    n = 0;
    while (st1[b] !== v && n < 4000) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    chk(n < 4000, 1'b1);
  endtask

  task automatic idle20();
    repeat (20) @(posedge clk_in);
    #1;
  endtask

  initial begin
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1'b1;
    wait_in <= 1'b1;
    @(posedge clk_in);
    #1;
    chk(st1, 8'h00);
    acc(CRW, 8'h2c);
    chk(ctl, 8'h20);
    chk(psel, 1'b1);
    acc(CCW, 8'h01);
    chk(ccr, 8'h01);
    acc(CRW, 8'h2d);
    wfs(S1_SB, 1'b1);
    chk(st1, 8'h83);
    chk(irq, 1'b1);
    @(posedge clk_in);
    imask <= 1'b1;
    idle20();
    chk(irq, 1'b0);
    chk(pins.scl_oe, 1'b1);
    @(posedge clk_in);
    imask <= 1'b0;
    acc(S1R, 8'h00);
    acc(DRW, 8'h54);
    wfs(S1_EVF, 1'b1);
    chk(st1, 8'h82);
    chk(bits, {8'h54, 1'b0});
    chk(per, 6);
    acc(S1R, 8'h00);
    acc(CRW, 8'h25);
    idle20();
    chk(pins.scl_oe, 1'b1);
    acc(S1R, 8'h00);
    acc(DRW, 8'ha5);
    wfs(S1_BTF, 1'b1);
    chk(st1, 8'haa);
    chk(bits, {8'ha5, 1'b0});
    @(posedge clk_in);
    nack <= 1'b1;
    acc(S1R, 8'h00);
    acc(DRW, 8'h3c);
    wfs(S1_EVF, 1'b1);
    chk(st2, 8'h10);
    idle20();
    chk(pins.scl_oe, 1'b0);
    acc(S2R, 8'h00);
    chk(st2, 8'h00);
    @(posedge clk_in);
    nack <= 1'b0;
    acc(CRW, 8'h27);
    wfs(S1_MSL, 1'b0);
    chk(ctl, 8'h25);
    acc(CCW, 8'h82);
    acc(CRW, 8'h2d);
    wfs(S1_SB, 1'b1);
    acc(S1R, 8'h00);
    acc(DRW, 8'h55);
    wfs(S1_EVF, 1'b1);
    chk(per, 12);
    acc(S1R, 8'h00);
    acc(CRW, 8'h25);
    wfs(S1_BTF, 1'b1);
    chk(st1, 8'h8a);
    chk(dat, 8'hc3);
    chk(bits, {8'hc3, 1'b0});
    idle20();
    chk(pins.scl_oe, 1'b1);
    acc(CRW, 8'h21);
    acc(S1R, 8'h00);
    acc(DRR, 8'h00);
    chk(st1[S1_BTF], 1'b0);
    wfs(S1_BTF, 1'b1);
    chk(dat, 8'hc4);
    chk(bits, {8'hc4, 1'b1});
    acc(CRW, 8'h23);
    acc(S1R, 8'h00);
    acc(DRR, 8'h00);
    wfs(S1_MSL, 1'b0);
    chk(bits, 9'h112);
    chk(ctl, 8'h21);
    @(posedge clk_in);
    halt_in <= 1'b1;
    acc(CRW, 8'h2d);
    chk(ctl, 8'h21);
    chk(st1, 8'h00);
    @(posedge clk_in);
    halt_in <= 1'b0;
    acc(CRW, 8'h00);
    chk(ctl, 8'h00);
    chk(psel, 1'b0);
    chk(ccr, 8'h82);
    give_verdict();
  end
endmodule
